// ---- hw/relay_output_command_logic.sv ----
// Command logic for the relay outputs: modes, remote commands, retention.
// Assumes all inputs come from logic on clk and one tick per half cycle.
//
// How it works
// - Twenty-four relay outputs in three groups of eight.
// - Each relay has its own mode: latched, unlatched, pulse or toggle.
// - Inverted relays are energized when inactive, de-energized when operated.
// - Unlatched relays follow the local operate level and release without latching.
// - Latched relays stay operated until a local or remote release.
// - Local release only clears the latch; a held remote operate keeps the relay operated.
// - Pulse mode gives one pulse, then holds released one width.
// - Pulse width programmable from 10 ms to 1 s.
// - Relays update on half-cycle ticks; widths round up to whole ticks.
// - Toggle mode inverts state per command, then holds one width.
// - Pulse and toggle relays accept internal pulse sources as commands.
// - Remote operate holds latched or unlatched relays until remote release.
// - Remote release also clears the local latch.
// - Remote operate triggers pulse or toggle; remote release ignored there.
// - Retention applies only to relays in latched mode.
// - After power returns non-retained relays and their remote commands clear.
// - After power returns retained relays keep state and remote commands.
// - Critical fault releases every relay and drops pending remote commands.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps

module relay_output_command_logic (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic half_cycle_tick,
    input wire logic power_restore,
    input wire logic critical_fault,
    input wire relay_pkg::local_cmd_t local_i,
    input wire relay_pkg::wb_req_t wb_i,
    output relay_pkg::wb_rsp_t wb_o,
    output logic [relay_pkg::NUM_RELAYS-1:0] relay_drive
);
    import relay_pkg::*;

    localparam int N = NUM_RELAYS;

    // Configuration and event registers.
    mode_t mode_r [N];
    mode_t mode_nxt [N];
    logic [N-1:0] invert_r, invert_nxt;
    logic [N-1:0] retain_r, retain_nxt;
    logic [9:0] pulse_ms_r, pulse_ms_nxt;
    logic [19:0] half_us_r, half_us_nxt;
    logic [N-1:0] rem_op_r, rem_op_nxt;
    logic [N-1:0] rem_rel_r, rem_rel_nxt;
    logic [N-1:0] loc_op_r, loc_op_nxt;
    logic [N-1:0] loc_rel_r, loc_rel_nxt;
    logic [N-1:0] src_r, src_nxt;
    logic [N-1:0] op_prev_r, op_prev_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic [N-1:0] drive_r, drive_nxt;

    // Per-relay state.
    logic active_r [N];
    logic active_nxt [N];
    logic latch_r [N];
    logic latch_nxt [N];
    logic remote_r [N];
    logic remote_nxt [N];
    phase_t phase_r [N];
    phase_t phase_nxt [N];
    logic [19:0] elapsed_r [N];
    logic [19:0] elapsed_nxt [N];

    logic [N-1:0] active_vec, remote_vec, latch_vec, busy_vec, hold_vec;
    logic [19:0] width_us;
    logic req;
    logic wr;
    logic [7:0] word_adr;
    logic [31:0] lane_mask;
    logic [31:0] wdat;
    logic [9:0] new_ms;

    assign width_us = 20'(pulse_ms_r) * US_PER_MS;
    assign req = wb_i.cyc & wb_i.stb & ~ack_r;
    assign wr = req & wb_i.we;
    assign word_adr = {wb_i.adr[7:2], 2'b00};
    assign lane_mask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}},
                        {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
    assign wb_o.ack = ack_r;
    assign wb_o.dat = rdat_r;
    assign relay_drive = drive_r;

    // Register write, read and event capture.
    always_comb begin
        logic [31:0] merged;
        logic [N-1:0] ev_rop;
        logic [N-1:0] ev_rrel;
        logic [N-1:0] keep;
        merged = 32'h00000000;
        ev_rop = '0;
        ev_rrel = '0;
        keep = '1;
        new_ms = pulse_ms_r;
        wdat = wb_i.dat & lane_mask;
        for (int k = 0; k < N; k++) begin
            mode_nxt[k] = mode_r[k];
        end
        invert_nxt = invert_r;
        retain_nxt = retain_r;
        pulse_ms_nxt = pulse_ms_r;
        half_us_nxt = half_us_r;
        rdat_nxt = 32'h00000000;
        ack_nxt = req;
        for (int k = 0; k < N; k++) begin
            if (wr && word_adr == 8'(ADR_MODE0 + 8'(ADR_MODE_STEP * 8'(k / 8)))
                && wb_i.sel[(k % 8) / 4]) begin
                mode_nxt[k] = mode_t'(wb_i.dat[MODE_W*(k % 8) +: MODE_W]);
            end
            if (word_adr == 8'(ADR_MODE0 + 8'(ADR_MODE_STEP * 8'(k / 8)))) begin
                rdat_nxt[MODE_W*(k % 8) +: MODE_W] = mode_r[k];
            end
        end
        if (wr) begin
            case (word_adr)
                ADR_INVERT: begin
                    merged = (32'(invert_r) & ~lane_mask) | wdat;
                    invert_nxt = merged[N-1:0];
                end
                ADR_RETAIN: begin
                    merged = (32'(retain_r) & ~lane_mask) | wdat;
                    retain_nxt = merged[N-1:0];
                end
                ADR_PULSE_MS: begin
                    merged = (32'(pulse_ms_r) & ~lane_mask) | wdat;
                    new_ms = merged[9:0];
                    if (merged[31:10] != 22'h000000 || new_ms > PULSE_MS_MAX) begin
                        new_ms = PULSE_MS_MAX;
                    end else if (new_ms < PULSE_MS_MIN) begin
                        new_ms = PULSE_MS_MIN;
                    end
                    pulse_ms_nxt = new_ms;
                end
                ADR_HALF_US: begin
                    merged = (32'(half_us_r) & ~lane_mask) | wdat;
                    if (merged[19:0] != 20'h00000) begin
                        half_us_nxt = merged[19:0];
                    end
                end
                ADR_REM_OP: begin
                    ev_rop = wdat[N-1:0];
                end
                ADR_REM_REL: begin
                    ev_rrel = wdat[N-1:0];
                end
                default: begin
                end
            endcase
        end
        case (word_adr)
            ADR_INVERT: rdat_nxt = 32'(invert_r);
            ADR_RETAIN: rdat_nxt = 32'(retain_r);
            ADR_PULSE_MS: rdat_nxt = 32'(pulse_ms_r);
            ADR_HALF_US: rdat_nxt = 32'(half_us_r);
            ADR_REM_OP: rdat_nxt = 32'(rem_op_r);
            ADR_REM_REL: rdat_nxt = 32'(rem_rel_r);
            ADR_DRIVE: rdat_nxt = 32'(drive_r);
            ADR_ACTIVE: rdat_nxt = 32'(active_vec);
            ADR_REMOTE: rdat_nxt = 32'(remote_vec);
            ADR_LATCH: rdat_nxt = 32'(latch_vec);
            ADR_BUSY: rdat_nxt = 32'(busy_vec);
            default: begin
            end
        endcase
        if (!req || wb_i.we) begin
            rdat_nxt = 32'h00000000;
        end
        // Pending events are consumed on the tick; a new one wins.
        rem_op_nxt = (rem_op_r & ~{N{half_cycle_tick}}) | ev_rop;
        rem_rel_nxt = (rem_rel_r & ~{N{half_cycle_tick}}) | ev_rrel;
        loc_op_nxt = (loc_op_r & ~{N{half_cycle_tick}})
                     | (local_i.operate & ~op_prev_r);
        loc_rel_nxt = (loc_rel_r & ~{N{half_cycle_tick}}) | local_i.release_cmd;
        src_nxt = (src_r & ~{N{half_cycle_tick}}) | local_i.pulse_src;
        op_prev_nxt = local_i.operate;
        // Power return drops events of non-retained relays.
        if (power_restore) begin
            keep = hold_vec;
        end
        // Critical fault drops every pending command.
        if (critical_fault) begin
            keep = '0;
        end
        rem_op_nxt = rem_op_nxt & keep;
        rem_rel_nxt = rem_rel_nxt & keep;
        loc_op_nxt = loc_op_nxt & keep;
        loc_rel_nxt = loc_rel_nxt & keep;
        src_nxt = src_nxt & keep;
        drive_nxt = active_vec ^ invert_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int k = 0; k < N; k++) begin
                mode_r[k] <= MODE_RST;
            end
            invert_r <= INVERT_RST;
            retain_r <= RETAIN_RST;
            pulse_ms_r <= PULSE_MS_RST;
            half_us_r <= HALF_US_RST;
            rem_op_r <= '0;
            rem_rel_r <= '0;
            loc_op_r <= '0;
            loc_rel_r <= '0;
            src_r <= '0;
            op_prev_r <= '0;
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
            drive_r <= INVERT_RST;
        end else begin
            for (int k = 0; k < N; k++) begin
                mode_r[k] <= mode_nxt[k];
            end
            invert_r <= invert_nxt;
            retain_r <= retain_nxt;
            pulse_ms_r <= pulse_ms_nxt;
            half_us_r <= half_us_nxt;
            rem_op_r <= rem_op_nxt;
            rem_rel_r <= rem_rel_nxt;
            loc_op_r <= loc_op_nxt;
            loc_rel_r <= loc_rel_nxt;
            src_r <= src_nxt;
            op_prev_r <= op_prev_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            drive_r <= drive_nxt;
        end
    end

    // One copy of the relay state machine per output.
    for (genvar i = 0; i < N; i++) begin : g_relay
        logic [20:0] sum;
        logic expire;
        logic trig;

        assign active_vec[i] = active_r[i];
        assign remote_vec[i] = remote_r[i];
        assign latch_vec[i] = latch_r[i];
        assign busy_vec[i] = (phase_r[i] != PH_IDLE);
        // Retention only counts in latched mode.
        assign hold_vec[i] = retain_r[i] & (mode_r[i] == MODE_LATCHED);
        // A phase ends at the first tick reaching the width.
        assign sum = {1'b0, elapsed_r[i]} + {1'b0, half_us_r};
        assign expire = (sum >= {1'b0, width_us});
        // Pulse sources and local or remote operate trigger.
        assign trig = rem_op_r[i] | loc_op_r[i] | src_r[i];

        always_comb begin
            active_nxt[i] = active_r[i];
            latch_nxt[i] = latch_r[i];
            remote_nxt[i] = remote_r[i];
            phase_nxt[i] = phase_r[i];
            elapsed_nxt[i] = elapsed_r[i];
            if (critical_fault) begin
                active_nxt[i] = 1'b0;
                latch_nxt[i] = 1'b0;
                remote_nxt[i] = 1'b0;
                phase_nxt[i] = PH_IDLE;
                elapsed_nxt[i] = 20'h00000;
            end else if (power_restore) begin
                if (!hold_vec[i]) begin
                    active_nxt[i] = 1'b0;
                    latch_nxt[i] = 1'b0;
                    remote_nxt[i] = 1'b0;
                    phase_nxt[i] = PH_IDLE;
                    elapsed_nxt[i] = 20'h00000;
                end
            end else if (half_cycle_tick) begin
                case (mode_r[i])
                    MODE_LATCHED, MODE_UNLATCHED: begin
                        if (rem_rel_r[i]) begin
                            remote_nxt[i] = 1'b0;
                            latch_nxt[i] = 1'b0;
                        end
                        if (rem_op_r[i]) begin
                            remote_nxt[i] = 1'b1;
                        end
                        if (mode_r[i] == MODE_LATCHED) begin
                            if (loc_rel_r[i]) begin
                                latch_nxt[i] = 1'b0;
                            end
                            if (local_i.operate[i]) begin
                                latch_nxt[i] = 1'b1;
                            end
                        end else begin
                            latch_nxt[i] = local_i.operate[i];
                        end
                        active_nxt[i] = latch_nxt[i] | remote_nxt[i];
                        phase_nxt[i] = PH_IDLE;
                        elapsed_nxt[i] = 20'h00000;
                    end
                    default: begin
                        remote_nxt[i] = 1'b0;
                        latch_nxt[i] = 1'b0;
                        elapsed_nxt[i] = sum[19:0];
                        case (phase_r[i])
                            PH_IDLE: begin
                                elapsed_nxt[i] = 20'h00000;
                                if (trig && mode_r[i] == MODE_PULSE) begin
                                    active_nxt[i] = 1'b1;
                                    phase_nxt[i] = PH_PULSE;
                                end else if (trig) begin
                                    active_nxt[i] = ~active_r[i];
                                    phase_nxt[i] = PH_HOLD;
                                end
                            end
                            PH_PULSE: begin
                                if (expire) begin
                                    active_nxt[i] = 1'b0;
                                    phase_nxt[i] = PH_HOLD;
                                    elapsed_nxt[i] = 20'h00000;
                                end
                            end
                            PH_HOLD: begin
                                if (expire) begin
                                    phase_nxt[i] = PH_IDLE;
                                    elapsed_nxt[i] = 20'h00000;
                                end
                            end
                            default: begin
                                phase_nxt[i] = PH_IDLE;
                            end
                        endcase
                    end
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (sys_rst) begin
                active_r[i] <= 1'b0;
                latch_r[i] <= 1'b0;
                remote_r[i] <= 1'b0;
                phase_r[i] <= PH_IDLE;
                elapsed_r[i] <= 20'h00000;
            end else begin
                active_r[i] <= active_nxt[i];
                latch_r[i] <= latch_nxt[i];
                remote_r[i] <= remote_nxt[i];
                phase_r[i] <= phase_nxt[i];
                elapsed_r[i] <= elapsed_nxt[i];
            end
        end
    end

endmodule

// ---- pkg/relay_pkg.sv ----
// Shared constants, types and register map of the relay command logic.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data.
package relay_pkg;

    localparam int NUM_RELAYS = 24;
    localparam int GROUP_SIZE = 8;
    localparam int NUM_GROUPS = NUM_RELAYS / GROUP_SIZE;
    localparam int MODE_W = 2;

    typedef enum logic [1:0] {
        MODE_UNLATCHED,
        MODE_LATCHED,
        MODE_PULSE,
        toggle_transition_mode
    } mode_t;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_PULSE,
        PH_HOLD
    } phase_t;

    // Register byte addresses; mode groups follow each other by one word.
    localparam logic [7:0] ADR_MODE0 = 8'h00;
    localparam logic [7:0] ADR_MODE_STEP = 8'h04;
    localparam logic [7:0] ADR_INVERT = 8'h0c;
    localparam logic [7:0] ADR_RETAIN = 8'h10;
    localparam logic [7:0] ADR_PULSE_MS = 8'h14;
    localparam logic [7:0] ADR_HALF_US = 8'h18;
    localparam logic [7:0] ADR_REM_OP = 8'h1c;
    localparam logic [7:0] ADR_REM_REL = 8'h20;
    localparam logic [7:0] ADR_DRIVE = 8'h24;
    localparam logic [7:0] ADR_ACTIVE = 8'h28;
    localparam logic [7:0] ADR_REMOTE = 8'h2c;
    localparam logic [7:0] ADR_LATCH = 8'h30;
    localparam logic [7:0] ADR_BUSY = 8'h34;

    // Reset values and limits.
    localparam mode_t MODE_RST = MODE_UNLATCHED;
    localparam logic [23:0] INVERT_RST = 24'h000000;
    localparam logic [23:0] RETAIN_RST = 24'h000000;
    localparam logic [9:0] PULSE_MS_MIN = 10'h00a;
    localparam logic [9:0] PULSE_MS_MAX = 10'h3e8;
    localparam logic [9:0] PULSE_MS_RST = 10'h064;
    localparam logic [19:0] HALF_US_RST = 20'h02710;
    localparam logic [19:0] US_PER_MS = 20'h003e8;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [NUM_RELAYS-1:0] operate;
        logic [NUM_RELAYS-1:0] release_cmd;
        logic [NUM_RELAYS-1:0] pulse_src;
    } local_cmd_t;

endpackage

// ---- tb/relay_output_command_logic_asserts.sv ----
// Port-level checker for the relay command logic, bound to the top module.
// Assumes one clock domain and the hand-over timing of the register bus.
`timescale 1ns/1ps
module relay_output_command_logic_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic half_cycle_tick,
    input wire logic power_restore,
    input wire logic critical_fault,
    input wire relay_pkg::local_cmd_t local_i,
    input wire relay_pkg::wb_req_t wb_i,
    input wire relay_pkg::wb_rsp_t wb_o,
    input wire logic [relay_pkg::NUM_RELAYS-1:0] relay_drive
);
    import relay_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence bus_req_s;
        wb_i.cyc && wb_i.stb && !wb_o.ack;
    endsequence
    sequence rd_unmapped_s;
        bus_req_s ##0 (!wb_i.we && wb_i.adr >= 8'h38);
    endsequence
    chk_ack_follows: assert property (bus_req_s |=> wb_o.ack)
        else $error("bus request not answered in one cycle");
    chk_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
        else $error("ack without a request");
    chk_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
        else $error("read data outside ack");
    chk_unmapped_zero: assert property (rd_unmapped_s |=> wb_o.dat == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !wb_o.ack && relay_drive == '0)
        else $error("outputs active after reset");
    chk_tick_only: assert property ($changed(relay_drive) |->
        $past(half_cycle_tick, 2) || $past(wb_o.ack)
        || $past(critical_fault, 2) || $past(power_restore, 2))
        else $error("relay drive moved without a tick");
    chk_fault_hold: assert property (critical_fault [*4] |->
        $stable(relay_drive) || $past(wb_o.ack))
        else $error("relay drive moved during fault");
    cover property (critical_fault ##1 critical_fault);
endmodule

bind relay_output_command_logic relay_output_command_logic_asserts u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .half_cycle_tick(half_cycle_tick),
    .power_restore(power_restore),
    .critical_fault(critical_fault),
    .local_i(local_i),
    .wb_i(wb_i),
    .wb_o(wb_o),
    .relay_drive(relay_drive)
);

// ---- tb/half_cycle_source.sv ----
// Half power cycle strobe standing in for the surrounding timing logic.
// Assumes it shares clk and sys_rst with the relay block.
`timescale 1ns/1ps
module half_cycle_source #(
    parameter int PERIOD = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    output logic half_cycle_tick
);
    int cnt_r;
    always_ff @(posedge clk) begin
        if (sys_rst || cnt_r == PERIOD - 1) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_r + 1;
        end
        half_cycle_tick <= !sys_rst && cnt_r == PERIOD - 1;
    end
endmodule

// ---- tb/relay_output_command_logic_tb_top.sv ----
// Self-checking bench for the relay command logic.
// Assumes a free tick source and a classic Wishbone master in this module.
`timescale 1ns/1ps
module relay_output_command_logic_tb_top;
    import relay_pkg::*;
    logic clk, sys_rst, power_restore, critical_fault, half_cycle_tick;
    local_cmd_t loc;
    wb_req_t req;
    wb_rsp_t rsp;
    logic [23:0] relay_drive;
    logic [31:0] q, r;
    int errors, samples_checked, cycles, k, n;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    half_cycle_source #(.PERIOD(16)) u_src (.clk(clk), .sys_rst(sys_rst),
        .half_cycle_tick(half_cycle_tick));
    relay_output_command_logic u_dut (.clk(clk), .sys_rst(sys_rst),
        .half_cycle_tick(half_cycle_tick), .power_restore(power_restore),
        .critical_fault(critical_fault), .local_i(loc), .wb_i(req),
        .wb_o(rsp), .relay_drive(relay_drive));

    // Ticks of pulse width, rounded up to whole half cycles.
    function automatic int exp_ticks(input int ms, input int us);
        return (ms * 1000 + us - 1) / us;
    endfunction

    task automatic complete_run();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        int w;
        w = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        do begin
            @(posedge clk);
            w++;
        end while (rsp.ack !== 1'b1 && w < 20);
        q = rsp.dat;
        req <= '0;
        check(32'(w < 20), 32'h1);
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(q, e);
    endtask

    task automatic ticks(input int t);
        repeat (t) @(posedge clk iff half_cycle_tick);
        repeat (2) @(posedge clk);
    endtask

    task automatic drv(input logic [23:0] e);
        check({8'h00, relay_drive}, {8'h00, e});
    endtask

    task automatic evt(input logic [23:0] rel, input logic [23:0] src);
        // Events start just after a tick, so the next tick takes them.
        @(posedge clk iff half_cycle_tick);
        loc.release_cmd <= rel;
        loc.pulse_src <= src;
        @(posedge clk);
        loc.release_cmd <= '0;
        loc.pulse_src <= '0;
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        {power_restore, critical_fault, loc, req} = '0;
        {errors, samples_checked, cycles} = '0;
        sys_rst = 1'b1;
        r = $urandom(43);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(ADR_PULSE_MS, 32'h64);
        rd(ADR_HALF_US, 32'h2710);
        rd(ADR_MODE0, 32'h0);
        rd(ADR_INVERT, 32'h0);
        bus(1'b1, 8'h40, 32'hffffffff);
        rd(8'h40, 32'h0);
        bus(1'b1, ADR_PULSE_MS, 32'h5);
        rd(ADR_PULSE_MS, 32'ha);
        bus(1'b1, ADR_PULSE_MS, 32'h7d0);
        rd(ADR_PULSE_MS, 32'h3e8);
        r = 32'ha + $urandom_range(990);
        bus(1'b1, ADR_PULSE_MS, r);
        rd(ADR_PULSE_MS, r);
        r = $urandom;
        bus(1'b1, ADR_MODE_STEP + ADR_MODE_STEP, r);
        rd(ADR_MODE_STEP + ADR_MODE_STEP, r & 32'hffff);
        bus(1'b1, ADR_PULSE_MS, 32'ha);
        bus(1'b1, ADR_HALF_US, 32'hbb8);
        k = exp_ticks(10, 3000);
        bus(1'b1, ADR_MODE0, 32'h1e4);
        rd(ADR_MODE0, 32'h1e4);
        loc.operate <= 24'h3;
        ticks(2);
        drv(24'h3);
        loc.operate <= '0;
        ticks(2);
        drv(24'h2);
        evt(24'h2, '0);
        ticks(2);
        drv(24'h0);
        bus(1'b1, ADR_REM_OP, 32'h3);
        ticks(2);
        evt(24'h2, '0);
        ticks(2);
        drv(24'h3);
        bus(1'b1, ADR_REM_REL, 32'h1);
        ticks(2);
        drv(24'h2);
        loc.operate <= 24'h2;
        ticks(2);
        loc.operate <= '0;
        bus(1'b1, ADR_REM_REL, 32'h2);
        ticks(2);
        drv(24'h0);
        evt('0, 24'h4);
        ticks(1);
        bus(1'b1, ADR_REM_REL, 32'h4);
        n = 0;
        while (relay_drive[2] === 1'b1 && n < 40) begin
            ticks(1);
            n++;
        end
        check(32'(n), 32'(k));
        evt('0, 24'h4);
        ticks(2);
        drv(24'h0);
        ticks(k);
        drv(24'h0);
        bus(1'b1, ADR_REM_OP, 32'h4);
        ticks(1);
        drv(24'h4);
        ticks(2 * k + 1);
        bus(1'b1, ADR_REM_OP, 32'h8);
        ticks(1);
        drv(24'h8);
        bus(1'b1, ADR_REM_OP, 32'h8);
        ticks(1);
        drv(24'h8);
        ticks(k);
        evt('0, 24'h8);
        ticks(1);
        drv(24'h0);
        bus(1'b1, ADR_INVERT, 32'h1);
        repeat (2) @(posedge clk);
        drv(24'h1);
        bus(1'b1, ADR_REM_OP, 32'h3);
        ticks(1);
        drv(24'h2);
        critical_fault <= 1'b1;
        repeat (3) @(posedge clk);
        drv(24'h1);
        rd(ADR_REMOTE, 32'h0);
        critical_fault <= 1'b0;
        ticks(2);
        drv(24'h1);
        bus(1'b1, ADR_RETAIN, 32'h3);
        bus(1'b1, ADR_REM_OP, 32'h13);
        ticks(1);
        drv(24'h12);
        power_restore <= 1'b1;
        @(posedge clk);
        power_restore <= 1'b0;
        ticks(1);
        drv(24'h3);
        rd(ADR_REMOTE, 32'h2);
        complete_run();
    end
endmodule
